// >>> src/dfs_pkg.sv
// Purpose: shared constants and types for the deferred frame store
// Assumes: one 100 MHz clock, registers reached over AXI4-Lite
// Notes: queue depth and frame size are fixed at build time
package dfs_pkg;
	// register byte addresses
	localparam logic [31:0] CTRL_ADDR     = 32'hF1000260;
	localparam logic [31:0] MODE_ADDR     = 32'hF1000264;
	localparam logic [31:0] PKT_ADDR      = 32'hF1000268;
	// deferred_transport_control field positions
	localparam int          PRESENT_BIT   = 31;
	localparam int          SEND_BIT      = 26;
	localparam int          HOLD_BIT      = 25;
	localparam int          CAP_LSB       = 8;
	// mode register field positions
	localparam int          BURST_BIT     = 0;
	localparam int          FMT7_BIT      = 1;
	// queue geometry
	localparam int          QUEUE_CAP     = 10;
	localparam int          FRAME_WORDS   = 16;
	localparam int          SLOT_W        = 4;
	localparam int          WORD_W        = 4;
	localparam int          ADDR_W        = 8;
	localparam int          MEM_DEPTH     = QUEUE_CAP * FRAME_WORDS;
	localparam logic [7:0]  CAP_CODE      = 8'h0A;
	// reset values
	localparam logic [15:0] PKT_RST       = 16'h0040;
	// isochronous cycle timing
	localparam int          ISO_PERIOD_NS = 125000;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          ISO_CYC_DEF   = ISO_PERIOD_NS / CLK_PERIOD_NS;
	// bus answers and register select codes
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [1:0]  SEL_NONE      = 2'h0;
	localparam logic [1:0]  SEL_CTRL      = 2'h1;
	localparam logic [1:0]  SEL_MODE      = 2'h2;
	localparam logic [1:0]  SEL_PKT       = 2'h3;

	// one word handed to the bus interface
	typedef struct packed {
		logic [31:0] data;
		logic        last_pkt;
		logic        last_frame;
	} dfs_beat_t;

	// readout sequencer states
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_GAP   = 5'b00010,
		TX_FETCH = 5'b00100,
		TX_READ  = 5'b01000,
		TX_SEND  = 5'b10000
	} dfs_tx_t;
endpackage

// >>> src/dfs_frame_mem.sv
// Purpose: frame slot storage, one write and one read port
// Assumes: same clock on both ports
// Notes: read data is registered, one cycle after the address
`timescale 1ns/10ps
module dfs_frame_mem (
	input  logic                      aclk,     // clock
	input  logic                      wr_en,    // write strobe
	input  logic [dfs_pkg::ADDR_W-1:0] wr_addr,  // write word address
	input  logic [31:0]               wr_data,  // write word
	input  logic [dfs_pkg::ADDR_W-1:0] rd_addr,  // read word address
	output logic [31:0]               rd_data   // registered read word
);
	import dfs_pkg::*;

	logic [31:0] mem_ff [MEM_DEPTH];
	logic [31:0] rd_data_ff;

	// write port
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	// read port, no reset so it maps onto block memory
	always_ff @(posedge aclk) begin
		rd_data_ff <= mem_ff[rd_addr];
	end

	assign rd_data = rd_data_ff;
endmodule

// >>> src/dfs_top.sv
// Purpose: deferred frame store, sensor frames into a queue, out to the bus link
// Assumes: sensor words and link ready come from logic on aclk
// Notes: frames have a fixed word count; one packet per isochronous cycle
//
// Overview of operation
// RQ1 - Frame storage holds a whole number of frames (32/64 MByte in silicon).
// RQ2 - Queue is first in first out; frames leave in capture order.
// RQ3 - While hold is set and no send pending, no image data leaves.
// RQ4 - While holding, every captured frame is written into the queue.
// RQ5 - Read-only capacity field reports maximum frames the queue holds.
// RQ6 - Capturing beyond capacity overwrites the oldest stored frame.
// RQ7 - Setting send transmits the number of frames in the count field.
// RQ8 - Send with count zero transmits every frame currently held.
// RQ9 - Clearing hold discards all held frames without sending them.
// RQ10 - Host requests one frame less than capacity when capture continues.
// RQ11 - Stored count rises when a frame is fully written into the queue.
// RQ12 - Stored count falls when a frame's final packet reaches the link.
// RQ13 - Burst capture only takes effect while format 7 is active.
// RQ14 - Burst off: capture and readout both paced by packet byte count.
// RQ15 - Burst on: capture runs at full sensor rate.
// RQ16 - Burst on: readout still paced by packet byte count.
// RQ17 - Burst on: frames faster than the link are buffered in the queue.
// RQ18 - Control read shows presence bit and capacity in second byte.
// RQ19 - Host enables hold writing hold set, count zero, presence kept.
// RQ20 - Host requests one frame writing hold, send and count one.
// RQ21 - Control read while holding shows stored frame count in low byte.
// RQ22 - Send bit clears itself once requested frames reach the link.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module dfs_top #(
	parameter int ISO_CYCLES = dfs_pkg::ISO_CYC_DEF // clocks per isochronous cycle
) (
	input  logic              aclk,        // 100 MHz clock
	input  logic              aresetn,     // synchronous reset, active low
	input  logic [31:0]       awaddr,      // write address
	input  logic              awvalid,     // write address valid
	output logic              awready,     // write address ready
	input  logic [31:0]       wdata,       // write data
	input  logic [3:0]        wstrb,       // write byte enables
	input  logic              wvalid,      // write data valid
	output logic              wready,      // write data ready
	output logic [1:0]        bresp,       // write response
	output logic              bvalid,      // write response valid
	input  logic              bready,      // write response ready
	input  logic [31:0]       araddr,      // read address
	input  logic              arvalid,     // read address valid
	output logic              arready,     // read address ready
	output logic [31:0]       rdata,       // read data
	output logic [1:0]        rresp,       // read response
	output logic              rvalid,      // read data valid
	input  logic              rready,      // read data ready
	input  logic              sen_valid,   // sensor word valid
	input  logic [31:0]       sen_data,    // sensor word
	output logic              sen_ready,   // sensor word accepted
	output logic              iso_valid,   // link beat valid
	output dfs_pkg::dfs_beat_t iso_beat,   // link beat payload
	input  logic              iso_ready    // link takes beat
);
	import dfs_pkg::*;

	// address decode shared by both bus directions
	function automatic logic [1:0] reg_sel(input logic [31:0] a);
		case (a)
			CTRL_ADDR: reg_sel = SEL_CTRL;
			MODE_ADDR: reg_sel = SEL_MODE;
			PKT_ADDR:  reg_sel = SEL_PKT;
			default:   reg_sel = SEL_NONE;
		endcase
	endfunction

	// byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		merge = r;
	endfunction

	// slot pointer step with wrap at capacity
	function automatic logic [SLOT_W-1:0] step(input logic [SLOT_W-1:0] p);
		step = (p == SLOT_W'(QUEUE_CAP - 1)) ? '0 : p + 1'b1;
	endfunction

	logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [31:0]       rdata_ff, aw_addr_ff, w_data_ff;
	logic [3:0]        w_strb_ff;
	logic              aw_have_ff, w_have_ff;
	logic              hold_ff, send_ff, burst_ff, fmt7_ff;
	logic [15:0]       pkt_bytes_ff;
	logic [7:0]        req_left_ff, stored_ff;
	logic [SLOT_W-1:0] wr_slot_ff, rd_slot_ff;
	logic [WORD_W-1:0] wr_word_ff, rd_word_ff;
	logic [13:0]       pkt_left_ff, budget_ff;
	logic [15:0]       iso_cnt_ff;
	logic              tick_ff, sen_ready_ff, iso_valid_ff;
	dfs_beat_t         iso_beat_ff;
	dfs_tx_t           tx_ff;
	logic [31:0]       ctrl_rd, wr_new, mem_q;
	logic              wr_go, ctrl_wr, flush, burst_eff, tx_en;
	logic              sen_take, frame_in, frame_out, drop_old;
	logic [13:0]       pkt_words, nxt_budget;
	logic [7:0]        nxt_req;

	// control word as software sees it
	always_comb begin
		ctrl_rd                         = '0;
		ctrl_rd[PRESENT_BIT]            = 1'b1;            // see RQ18
		ctrl_rd[SEND_BIT]               = send_ff;
		ctrl_rd[HOLD_BIT]               = hold_ff;
		ctrl_rd[CAP_LSB +: 8]           = CAP_CODE;        // see RQ5
		ctrl_rd[7:0]                    = stored_ff;       // see RQ21
	end

	// write strobes and event terms
	assign wr_go     = aw_have_ff & w_have_ff & ~bvalid_ff;
	assign ctrl_wr   = wr_go & (reg_sel(aw_addr_ff) == SEL_CTRL);
	assign wr_new    = merge(ctrl_rd, w_data_ff, w_strb_ff);
	assign flush     = ctrl_wr & hold_ff & ~wr_new[HOLD_BIT]; // see RQ9
	assign nxt_req   = (wr_new[7:0] == 8'h00) ? stored_ff : wr_new[7:0]; // see RQ7 RQ8
	assign burst_eff = burst_ff & fmt7_ff;                 // see RQ13
	assign tx_en     = ~hold_ff | send_ff;                 // see RQ3
	assign sen_take  = sen_valid & sen_ready_ff;
	assign frame_in  = sen_take & (wr_word_ff == WORD_W'(FRAME_WORDS - 1));
	assign frame_out = iso_valid_ff & iso_ready & iso_beat_ff.last_frame;
	assign drop_old  = frame_in & ~frame_out & (stored_ff == CAP_CODE); // see RQ6
	assign pkt_words = (pkt_bytes_ff[15:2] == 14'h0000) ? 14'h0001 : pkt_bytes_ff[15:2];

	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 32'h00000000;
			w_data_ff  <= 32'h00000000;
			w_strb_ff  <= 4'h0;
		end else begin
			if (awvalid & awready_ff) begin
				aw_addr_ff <= awaddr;
				aw_have_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (wvalid & wready_ff) begin
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
				w_have_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
			end
			if (bvalid_ff & bready) begin
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// write response, unmapped addresses answer slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (reg_sel(aw_addr_ff) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read channel, data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= RESP_OKAY;
		end else if (arvalid & arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= RESP_OKAY;
			case (reg_sel(araddr))
				SEL_CTRL: rdata_ff <= ctrl_rd;                   // see RQ18 RQ21
				SEL_MODE: rdata_ff <= {30'h00000000, fmt7_ff, burst_ff};
				SEL_PKT:  rdata_ff <= {16'h0000, pkt_bytes_ff};
				default: begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff & rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// hold and send flags; send clears once its frames are out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_ff     <= 1'b0;
			send_ff     <= 1'b0;
			req_left_ff <= 8'h00;
		end else if (ctrl_wr) begin
			hold_ff     <= wr_new[HOLD_BIT];                 // see RQ4
			send_ff     <= wr_new[HOLD_BIT] & wr_new[SEND_BIT] & (nxt_req != 8'h00);
			req_left_ff <= nxt_req;                          // see RQ7 RQ8
		end else if (send_ff & frame_out) begin
			req_left_ff <= req_left_ff - 8'h01;
			if (req_left_ff == 8'h01) begin
				send_ff <= 1'b0;                             // see RQ22
			end
		end
	end

	// mode and packet size registers; burst needs format 7 in the same write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_ff     <= 1'b0;
			fmt7_ff      <= 1'b0;
			pkt_bytes_ff <= PKT_RST;
		end else if (wr_go & (reg_sel(aw_addr_ff) == SEL_MODE)) begin
			fmt7_ff  <= w_data_ff[FMT7_BIT];
			burst_ff <= w_data_ff[BURST_BIT] & w_data_ff[FMT7_BIT]; // see RQ13
		end else if (wr_go & (reg_sel(aw_addr_ff) == SEL_PKT)) begin
			pkt_bytes_ff <= 16'(merge({16'h0000, pkt_bytes_ff}, w_data_ff, w_strb_ff));
		end
	end

	// isochronous cycle tick, one packet may leave per tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iso_cnt_ff <= 16'h0000;
			tick_ff    <= 1'b0;
		end else begin
			tick_ff    <= (iso_cnt_ff == 16'(ISO_CYCLES - 1));
			iso_cnt_ff <= (iso_cnt_ff == 16'(ISO_CYCLES - 1)) ? 16'h0000 : iso_cnt_ff + 16'h0001;
		end
	end

	// capture budget: without burst, intake is held to the link's word rate
	assign nxt_budget = tick_ff ? pkt_words :
		(budget_ff - {13'h0000, sen_take & ~burst_eff});
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			budget_ff    <= 14'h0000;
			sen_ready_ff <= 1'b0;
		end else begin
			budget_ff    <= nxt_budget;                      // see RQ14
			sen_ready_ff <= burst_eff | (nxt_budget != 14'h0000); // see RQ15
		end
	end

	// capture side: words fill the write slot in order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_slot_ff <= '0;
			wr_word_ff <= '0;
		end else if (sen_take) begin
			wr_word_ff <= wr_word_ff + 1'b1;
			if (frame_in) begin
				wr_slot_ff <= step(wr_slot_ff);              // see RQ2 RQ4 RQ17
			end
		end
	end

	// stored count and read slot; overwrite drops the oldest frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stored_ff  <= 8'h00;
			rd_slot_ff <= '0;
		end else if (flush) begin
			stored_ff  <= 8'h00;                             // see RQ9
			rd_slot_ff <= frame_in ? step(wr_slot_ff) : wr_slot_ff;
		end else begin
			if (frame_out | drop_old) begin
				rd_slot_ff <= step(rd_slot_ff);              // see RQ2 RQ6
			end
			if (frame_in & ~frame_out & ~drop_old) begin
				stored_ff <= stored_ff + 8'h01;              // see RQ11
			end else if (frame_out & ~frame_in) begin
				stored_ff <= stored_ff - 8'h01;              // see RQ12
			end
		end
	end

	// readout sequencer; entering hold mid-frame restarts that frame later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ff        <= TX_IDLE;
			rd_word_ff   <= '0;
			pkt_left_ff  <= 14'h0000;
			iso_valid_ff <= 1'b0;
			iso_beat_ff  <= '0;
		end else if (!tx_en | flush | drop_old) begin
			tx_ff        <= TX_IDLE;                         // see RQ3
			rd_word_ff   <= '0;
			iso_valid_ff <= 1'b0;
		end else begin
			case (tx_ff)
				TX_IDLE: begin
					if (stored_ff != 8'h00) begin
						tx_ff <= TX_GAP;
					end
				end
				TX_GAP: begin
					if (tick_ff) begin
						pkt_left_ff <= pkt_words;            // see RQ16
						tx_ff       <= TX_FETCH;
					end
				end
				TX_FETCH: tx_ff <= TX_READ;
				TX_READ: begin
					iso_valid_ff         <= 1'b1;
					iso_beat_ff.data     <= mem_q;
					iso_beat_ff.last_frame <= (rd_word_ff == WORD_W'(FRAME_WORDS - 1));
					iso_beat_ff.last_pkt <= (pkt_left_ff == 14'h0001) |
						(rd_word_ff == WORD_W'(FRAME_WORDS - 1));
					tx_ff                <= TX_SEND;
				end
				TX_SEND: begin
					if (iso_ready) begin
						iso_valid_ff <= 1'b0;
						rd_word_ff   <= rd_word_ff + 1'b1;
						pkt_left_ff  <= pkt_left_ff - 14'h0001;
						if (iso_beat_ff.last_frame) begin
							tx_ff <= TX_IDLE;                // see RQ12
						end else if (iso_beat_ff.last_pkt) begin
							tx_ff <= TX_GAP;
						end else begin
							tx_ff <= TX_FETCH;
						end
					end
				end
				default: tx_ff <= TX_IDLE;
			endcase
		end
	end

	// frame storage, slot-major word addressing
	dfs_frame_mem u_mem (                                    // see RQ1
		.aclk    (aclk),
		.wr_en   (sen_take),
		.wr_addr ({wr_slot_ff, wr_word_ff}),
		.wr_data (sen_data),
		.rd_addr ({rd_slot_ff, rd_word_ff}),
		.rd_data (mem_q)
	);

	assign awready   = awready_ff;
	assign wready    = wready_ff;
	assign bvalid    = bvalid_ff;
	assign bresp     = bresp_ff;
	assign arready   = arready_ff;
	assign rvalid    = rvalid_ff;
	assign rdata     = rdata_ff;
	assign rresp     = rresp_ff;
	assign sen_ready = sen_ready_ff;
	assign iso_valid = iso_valid_ff;
	assign iso_beat  = iso_beat_ff;

	// checks on the queue, the control and mode registers and capture pacing
	sequence s_ar_ctrl;
		arvalid & arready_ff & (reg_sel(araddr) == SEL_CTRL);
	endsequence
	sequence s_cap_seen;
		rvalid_ff & rdata_ff[PRESENT_BIT] & (rdata_ff[CAP_LSB +: 8] == CAP_CODE);
	endsequence
	property p_quiet;
		@(posedge aclk) disable iff (!aresetn) !tx_en |=> !iso_valid_ff;
	endproperty
	a_quiet: assert property (p_quiet) else $error("beat sent while holding"); // see RQ3
	property p_cnt_up;
		@(posedge aclk) disable iff (!aresetn)
		frame_in & !frame_out & !drop_old & !flush |=> stored_ff == $past(stored_ff) + 8'h01;
	endproperty
	a_cnt_up: assert property (p_cnt_up) else $error("count not raised"); // see RQ11
	property p_cnt_dn;
		@(posedge aclk) disable iff (!aresetn)
		frame_out & !frame_in & !flush |=> stored_ff == $past(stored_ff) - 8'h01;
	endproperty
	a_cnt_dn: assert property (p_cnt_dn) else $error("count not lowered"); // see RQ12
	property p_overwrite;
		@(posedge aclk) disable iff (!aresetn)
		drop_old & !flush |=> stored_ff == CAP_CODE && rd_slot_ff != $past(rd_slot_ff);
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("oldest not dropped"); // see RQ6
	property p_flush;
		@(posedge aclk) disable iff (!aresetn) flush |=> stored_ff == 8'h00 && !iso_valid_ff;
	endproperty
	a_flush: assert property (p_flush) else $error("queue kept after hold off"); // see RQ9
	property p_burst_gate;
		@(posedge aclk) disable iff (!aresetn)
		wr_go & (reg_sel(aw_addr_ff) == SEL_MODE) & !w_data_ff[FMT7_BIT] |=> !burst_ff && !burst_eff;
	endproperty
	a_burst_gate: assert property (p_burst_gate) else $error("burst without format 7"); // see RQ13
	property p_send_done;
		@(posedge aclk) disable iff (!aresetn)
		send_ff & frame_out & !ctrl_wr & req_left_ff == 8'h01 |=> !send_ff;
	endproperty
	a_send_done: assert property (p_send_done) else $error("send bit stuck"); // see RQ22
	property p_cap_read;
		@(posedge aclk) disable iff (!aresetn) s_ar_ctrl |=> s_cap_seen;
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capacity missing"); // see RQ5 RQ18
	property p_pace;
		@(posedge aclk) disable iff (!aresetn)
		sen_take & !burst_eff |-> budget_ff != 14'h0000;
	endproperty
	a_pace: assert property (p_pace) else $error("capture above packet rate"); // see RQ14
endmodule

// >>> verif/dfs_link_model.sv
// Purpose: link side stand-in, takes beats off the isochronous port
// Assumes: one clock; a beat moves when valid and ready are both high
// Notes: stall makes ready toggle, so the sender meets a slow taker
`timescale 1ns/10ps
module dfs_link_model (
	input  logic               aclk,      // clock
	input  logic               aresetn,   // reset, active low
	input  logic               stall,     // slow taking when high
	input  logic               iso_valid, // beat offered
	input  dfs_pkg::dfs_beat_t iso_beat,  // beat payload
	output logic               iso_ready, // beat taken
	output logic [31:0]        nb_ff,     // beats taken
	output logic [31:0]        nfr_ff,    // frames completed
	output logic [31:0]        lw_ff,     // last word of last frame
	output logic [31:0]        np_ff      // packets completed
);
	import dfs_pkg::*;

	// a stalled taker still takes every other cycle, never holds off for good
	always_ff @(posedge aclk) begin
		if (!aresetn)
			iso_ready <= 1'b0;
		else
			iso_ready <= stall ? !iso_ready : 1'b1;
	end

	// count beats, packets and whole frames handed over to the link
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nb_ff  <= 32'h00000000;
			nfr_ff <= 32'h00000000;
			lw_ff  <= 32'h00000000;
			np_ff  <= 32'h00000000;
		end else if (iso_valid && iso_ready) begin
			nb_ff <= nb_ff + 32'h00000001;
			if (iso_beat.last_pkt) begin
				np_ff <= np_ff + 32'h00000001;
			end
			if (iso_beat.last_frame) begin
				nfr_ff <= nfr_ff + 32'h00000001;
				lw_ff  <= iso_beat.data;
			end
		end
	end
endmodule

// >>> verif/deferred_frame_store_test.sv
// Purpose: self-checking bench for the deferred frame store
// Assumes: short isochronous cycle of 16 clocks, frames of 16 words
// Notes: frame words carry tag and index so order and drops show up
`timescale 1ns/10ps
module deferred_frame_store_test;
	import dfs_pkg::*;
	localparam int ISO = 16;
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic              sen_valid, stall, awready, wready, bvalid, arready, rvalid;
	logic              sen_ready, iso_valid, iso_ready;
	logic [31:0]       awaddr, wdata, araddr, rdata, sen_data, nb, nfr, lw, d, np;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	dfs_beat_t         iso_beat;
	int                mismatches, n_tests, c;

	dfs_top #(.ISO_CYCLES(ISO)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sen_valid(sen_valid), .sen_data(sen_data), .sen_ready(sen_ready),
		.iso_valid(iso_valid), .iso_beat(iso_beat), .iso_ready(iso_ready));
	dfs_link_model link (.aclk(aclk), .aresetn(aresetn), .stall(stall),
		.iso_valid(iso_valid), .iso_beat(iso_beat), .iso_ready(iso_ready),
		.nb_ff(nb), .nfr_ff(nfr), .lw_ff(lw), .np_ff(np));

	// clock and reset; every input gets a value at time zero
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sen_valid, stall} = '0;
		{awaddr, wdata, araddr, sen_data, wstrb} = '0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one write, address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		bit ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
			if (wvalid && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		// bready stays high, so back-to-back writes never drive it twice in one step
		r = bresp;
	endtask

	task automatic rd(input logic [31:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	// one frame of sensor words; c counts edges until the last word is taken
	task automatic frame(input logic [7:0] tag);
		c = 0;
		for (int i = 0; i < FRAME_WORDS; i++) begin
			sen_valid <= 1'b1;
			sen_data <= {16'h0000, tag, 8'(i)};
			do begin @(posedge aclk); c++; end while (sen_ready !== 1'b1);
		end
		sen_valid <= 1'b0;
		@(posedge aclk);
	endtask

	// poll until the send bit drops; the watchdog ends a hang
	task automatic wait_send();
		do rd(CTRL_ADDR); while (d[SEND_BIT] !== 1'b0);
	endtask

	task automatic t_reset();
		rd(CTRL_ADDR);
		chk(d, 32'h80000A00);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rd(PKT_ADDR);
		chk(d, 32'h00000040);
		rd(32'hF1000270);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(32'hF1000270, 32'h02000000);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
	endtask

	// read-only presence and capacity survive a write of zeros there
	task automatic t_hold();
		wr(CTRL_ADDR, 32'h02000000);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		frame(8'h01);
		frame(8'h02);
		rd(CTRL_ADDR);
		chk(d, 32'h82000A02);
		chk(nb, 32'h0);
	endtask

	task automatic t_send();
		wr(CTRL_ADDR, 32'h86000A01);
		wait_send();
		chk(d, 32'h82000A01);
		chk(lw, 32'h0000010F);
		stall <= 1'b1;
		frame(8'h03);
		frame(8'h04);
		wr(CTRL_ADDR, 32'h86000A00);
		wait_send();
		stall <= 1'b0;
		chk(d, 32'h82000A00);
		chk(nfr, 32'h4);
		chk(lw, 32'h0000040F);
	endtask

	// twelve frames into ten slots: the two oldest are lost
	task automatic t_over();
		for (int t = 5; t <= 16; t++) frame(8'(t));
		rd(CTRL_ADDR);
		chk(d, 32'h82000A0A);
		wr(CTRL_ADDR, 32'h86000A01);
		wait_send();
		chk(lw, 32'h0000070F);
		chk(d, 32'h82000A09);
	endtask

	task automatic t_flush();
		logic [31:0] n;
		n = nb;
		wr(CTRL_ADDR, 32'h80000A00);
		wr(CTRL_ADDR, 32'h82000A00);
		rd(CTRL_ADDR);
		chk(d, 32'h82000A00);
		chk(nb, n);
	endtask

	// one word per packet: slow capture unless burst is on with format 7
	task automatic t_burst();
		wr(PKT_ADDR, 32'h00000004);
		frame(8'h11);
		chk(32'(c > 100), 32'h1);
		wr(MODE_ADDR, 32'h00000001);
		rd(MODE_ADDR);
		chk(d, 32'h0);
		wr(MODE_ADDR, 32'h00000003);
		rd(MODE_ADDR);
		chk(d, 32'h3);
		frame(8'h12);
		chk(c, 32'd16);
		rd(CTRL_ADDR);
		chk(d, 32'h82000A02);
		wr(CTRL_ADDR, 32'h86000A00);
		wait_send();
		chk(nfr, 32'h7);
		chk(np, 32'h25);
		chk(nb, 32'h70);
		chk(lw, 32'h0000120F);
	endtask

	task automatic wrap_up();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence after 20 cycles of reset
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_hold();
		t_send();
		t_over();
		t_flush();
		t_burst();
		wrap_up();
	end

	// watchdog: far beyond the expected run of some 2000 cycles
	initial begin
		#(900000);
		mismatches++;
		wrap_up();
	end
endmodule
